//--- inc/intc_regs.svh
/*
 Register indices, field positions, reset values and sequence counts
 of the interrupt latch and arbiter. Assumes a byte-wide register port.
*/
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

`define NUM_SRC 22
`define STAT1_IDX 8'h00
`define STAT2_IDX 8'h01
`define STAT3_IDX 8'h02
`define CTRL_IDX 8'h03
`define CTRL_BREAK_CLEAR_ENABLE_BIT 0
`define CTRL_RST 8'h00
`define CTRL_BREAK_CLEAR_ENABLE_RST 1'b0
`define STAT2_RST 8'h00
`define CCR_I_BIT 3
`define STACK_LAST 3'h4
`define VEC_RESET 5'h00
`define VEC_SWI 5'h01
`define VEC_HW_BASE 5'h02

`endif

//--- inc/intc_pkg.sv
/*
 Types shared by the interrupt latch and arbiter and its CPU core.
 Assumes intc_regs.svh is on the include path.
*/
package intc_pkg;

	// signals from the CPU core, all on SYS_CLK
	typedef struct packed {
		logic insn_done;
		logic swi_exec;
		logic rti_exec;
		logic wait_exec;
		logic stop_exec;
		logic mask_set;
		logic mask_clr;
		logic [15:0] pc;
		logic [7:0] acc;
		logic [7:0] idx;
		logic [7:0] ccr;
		logic [7:0] pop_data;
	} cpu_in_t;

	// answers to the CPU core
	typedef struct packed {
		logic stack_push;
		logic stack_pop;
		logic [7:0] stack_data;
		logic vec_valid;
		logic [4:0] vec_sel;
		logic hold;
		logic mask;
	} cpu_out_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH,
		ST_VEC,
		ST_POP,
		ST_RCHK,
		ST_LOW
	} state_t;

endpackage

//--- rtl/interrupt_latch_and_arbiter.sv
/*
 Interrupt latch and arbiter: latches requests at instruction ends,
 arbitrates by fixed priority, drives stacking and vector selection,
 and guards peripheral flag clearing in break. Assumes the CPU core
 gives one-cycle event pulses and that request lines share SYS_CLK.
*/
`include "intc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module interrupt_latch_and_arbiter (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// CPU core
	input wire intc_pkg::cpu_in_t CPU_IN,
	output intc_pkg::cpu_out_t CPU_OUT,
	// interrupt sources, bit n-1 is flag n
	input wire logic [`NUM_SRC-1:0] SRC_REQ,
	input wire logic [`NUM_SRC-1:0] SRC_ENA,
	input wire logic BRK_REQ,
	// break flag protection
	output logic FLAG_CLR_OK,
	output logic IN_BREAK
);
	import intc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// fixed-priority pick: lowest flag number wins

	function automatic logic [4:0] pick(input logic [`NUM_SRC-1:0] v);
		logic [4:0] code;
		code = `VEC_HW_BASE;
		for (int i = `NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				code = 5'(i) + `VEC_HW_BASE;
			end
		end
		return code;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	state_t state_r;
	logic [2:0] cnt_r;
	logic [4:0] code_r;
	logic [15:0] spc_r;
	logic [7:0] sacc_r;
	logic [7:0] sidx_r;
	logic [7:0] sccr_r;
	logic mask_r;
	logic brk_r;
	logic brk_entry_r;
	logic ccr_due_r;
	logic break_clear_enable_r;
	logic [7:0] rdata_r;
	logic push_r;
	logic pop_r;
	logic [7:0] sdata_r;
	logic vvalid_r;
	logic [4:0] vsel_r;
	logic hold_r;
	logic clr_ok_r;
	logic [`NUM_SRC-1:0] pend;
	logic take;
	logic take_brk;
	logic [4:0] take_code;
	logic [15:0] take_pc;
	logic brk_exit;

	assign pend = SRC_REQ & SRC_ENA;
	assign brk_exit = state_r == ST_POP && cnt_r == `STACK_LAST && brk_entry_r;

	////////////////////////////////////////////////////////////////////////
	// take decision

	always_comb begin
		take = 1'b0;
		take_brk = 1'b0;
		take_code = `VEC_SWI;
		take_pc = CPU_IN.pc;
		case (state_r)
			ST_IDLE: begin
				if (CPU_IN.swi_exec) begin
					take = 1'b1;
				end else if (CPU_IN.insn_done && BRK_REQ) begin
					take = 1'b1;
					take_brk = 1'b1;
				end else if (CPU_IN.insn_done && !mask_r && |pend) begin
					take = 1'b1;
					take_code = pick(pend);
					take_pc = CPU_IN.pc - 16'h0001;
				end
			end
			ST_RCHK, ST_LOW: begin
				if (BRK_REQ) begin
					take = 1'b1;
					take_brk = 1'b1;
				end else if (!mask_r && |pend) begin
					take = 1'b1;
					take_code = pick(pend);
					take_pc = CPU_IN.pc - 16'h0001;
				end
			end
			default: begin
				take = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_r <= ST_VEC;
			code_r <= `VEC_RESET;
			cnt_r <= 3'h0;
		end else begin
			case (state_r)
				ST_IDLE, ST_RCHK, ST_LOW: begin
					if (take) begin
						state_r <= ST_PUSH;
						code_r <= take_code;
						cnt_r <= 3'h0;
					end else if (state_r == ST_RCHK) begin
						state_r <= ST_IDLE;
					end else if (state_r == ST_IDLE && CPU_IN.rti_exec) begin
						state_r <= ST_POP;
						cnt_r <= 3'h0;
					end else if (state_r == ST_IDLE &&
						(CPU_IN.wait_exec || CPU_IN.stop_exec)) begin
						state_r <= ST_LOW;
					end
				end
				// latched code held until vector issued
				ST_PUSH: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == `STACK_LAST) begin
						state_r <= ST_VEC;
					end
				end
				ST_VEC: begin
					state_r <= ST_IDLE;
				end
				ST_POP: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == `STACK_LAST) begin
						state_r <= ST_RCHK;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// snapshot of what is stacked
	// high index never captured, software keeps it

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			spc_r <= 16'h0000;
			sacc_r <= 8'h00;
			sidx_r <= 8'h00;
			sccr_r <= 8'h00;
		end else if (take) begin
			spc_r <= take_pc;
			sacc_r <= CPU_IN.acc;
			sidx_r <= CPU_IN.idx;
			// stacked mask is the value before entry
			sccr_r <= CPU_IN.ccr;
			sccr_r[`CCR_I_BIT] <= mask_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// global mask

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			mask_r <= 1'b1;
			ccr_due_r <= 1'b0;
		end else begin
			// popped CCR arrives the cycle after the first pop
			ccr_due_r <= state_r == ST_POP && cnt_r == 3'h1;
			if (take) begin
				mask_r <= 1'b1;
			end else if (ccr_due_r) begin
				mask_r <= CPU_IN.pop_data[`CCR_I_BIT];
			end else if (state_r == ST_IDLE &&
				(CPU_IN.wait_exec || CPU_IN.stop_exec)) begin
				mask_r <= 1'b0;
			end else if (CPU_IN.mask_set) begin
				mask_r <= 1'b1;
			end else if (CPU_IN.mask_clr) begin
				mask_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CPU-side outputs

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			push_r <= 1'b0;
			pop_r <= 1'b0;
			sdata_r <= 8'h00;
			vvalid_r <= 1'b0;
			vsel_r <= `VEC_RESET;
			hold_r <= 1'b0;
		end else begin
			// push order PCL, PCH, X, A, CCR
			push_r <= state_r == ST_PUSH;
			case (cnt_r)
				3'h0: sdata_r <= spc_r[7:0];
				3'h1: sdata_r <= spc_r[15:8];
				3'h2: sdata_r <= sidx_r;
				3'h3: sdata_r <= sacc_r;
				default: sdata_r <= sccr_r;
			endcase
			// pops CCR, A, X, PCH, PCL
			pop_r <= state_r == ST_POP;
			vvalid_r <= state_r == ST_VEC;
			if (state_r == ST_VEC) begin
				vsel_r <= code_r;
			end
			// CPU unclocked until a wake source
			if (state_r == ST_IDLE && !take &&
				(CPU_IN.wait_exec || CPU_IN.stop_exec)) begin
				hold_r <= 1'b1;
			end else if (take) begin
				hold_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// break state and flag protection

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			brk_r <= 1'b0;
			brk_entry_r <= 1'b0;
			clr_ok_r <= 1'b1;
		end else begin
			if (take) begin
				brk_entry_r <= take_brk;
			end
			if (take && take_brk) begin
				brk_r <= 1'b1;
			end else if (brk_exit) begin
				brk_r <= 1'b0;
			end
			// no restore, cleared flags stay cleared
			// one gate covers both steps of a clear
			// gate moves with break entry and exit, no stale cycle
			clr_ok_r <= break_clear_enable_r || !((take && take_brk) || (brk_r && !brk_exit));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register port

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			break_clear_enable_r <= `CTRL_BREAK_CLEAR_ENABLE_RST;
		end else if (REG_WR && REG_ADDR == `CTRL_IDX) begin
			break_clear_enable_r <= REG_WDATA[`CTRL_BREAK_CLEAR_ENABLE_BIT];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rdata_r <= `STAT2_RST;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`STAT1_IDX: rdata_r <= {SRC_REQ[5:0], 2'b00};
				// flag 14 at bit 7 to 7 at 0
				`STAT2_IDX: rdata_r <= SRC_REQ[13:6];
				`STAT3_IDX: rdata_r <= SRC_REQ[21:14];
				`CTRL_IDX: rdata_r <= {7'h00, break_clear_enable_r};
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output wiring, all from flops

	assign REG_RDATA = rdata_r;
	assign CPU_OUT.stack_push = push_r;
	assign CPU_OUT.stack_pop = pop_r;
	assign CPU_OUT.stack_data = sdata_r;
	assign CPU_OUT.vec_valid = vvalid_r;
	assign CPU_OUT.vec_sel = vsel_r;
	assign CPU_OUT.hold = hold_r;
	assign CPU_OUT.mask = mask_r;
	assign FLAG_CLR_OK = clr_ok_r;
	assign IN_BREAK = brk_r;

endmodule

`default_nettype wire

//--- tb/intc_properties.sv
/* port checker of the interrupt latch and arbiter
 assumes a bind to the top module and one clock domain */
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"
module intc_properties (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	// cpu core and sources
	input wire intc_pkg::cpu_in_t CPU_IN,
	input wire intc_pkg::cpu_out_t CPU_OUT,
	input wire logic [`NUM_SRC-1:0] SRC_REQ,
	input wire logic BRK_REQ,
	// break protection
	input wire logic FLAG_CLR_OK,
	input wire logic IN_BREAK
);
	import intc_pkg::*;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence push_run;
		CPU_OUT.stack_push [*5] ##1 CPU_OUT.vec_valid;
	endsequence
	////////////////////////////////////////////////
	chk_status_one: assert property (
		REG_RD && REG_ADDR == `STAT1_IDX |=>
		REG_RDATA == {$past(SRC_REQ[5:0]), 2'b00}) else $error("status 1");
	chk_status_two: assert property (
		REG_RD && REG_ADDR == `STAT2_IDX |=>
		REG_RDATA == $past(SRC_REQ[13:6])) else $error("status 2");
	chk_entry_run: assert property (
		$rose(CPU_OUT.stack_push) |-> push_run) else $error("entry run");
	chk_swi_pc: assert property (
		$rose(CPU_OUT.stack_push) && $past(CPU_IN.swi_exec, 2) |->
		CPU_OUT.stack_data == $past(CPU_IN.pc[7:0], 2)) else $error("swi pc");
	chk_hw_pc: assert property (
		$rose(CPU_OUT.stack_push) && $past(CPU_IN.insn_done, 2) &&
		!$past(CPU_IN.swi_exec, 2) && !$past(BRK_REQ, 2) |->
		CPU_OUT.stack_data == $past(CPU_IN.pc[7:0], 2) - 8'h01)
		else $error("hw pc");
	chk_clr_free: assert property (
		!IN_BREAK |-> FLAG_CLR_OK) else $error("clear gate");
	chk_break_vec: assert property (
		$rose(IN_BREAK) |-> ##[0:8]
		(CPU_OUT.vec_valid && CPU_OUT.vec_sel == `VEC_SWI))
		else $error("break vector");
	chk_hold_mask: assert property (
		$rose(CPU_OUT.hold) |-> !CPU_OUT.mask) else $error("hold mask");
	chk_pop_mask: assert property (
		$rose(CPU_OUT.stack_pop) ##1 1 |=>
		CPU_OUT.mask == $past(CPU_IN.pop_data[3])) else $error("pop mask");
	chk_reset_vec: assert property (
		$fell(RST) |-> ##[1:3]
		(CPU_OUT.vec_valid && CPU_OUT.vec_sel == `VEC_RESET))
		else $error("reset vector");
endmodule
`default_nettype wire

//--- tb/cpu_stack_model.sv
/* stack memory of the cpu core
 assumes one push or pop pulse per byte on the bus clock */
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_model (
	// clock
	input wire logic sys_clk,
	// stack port
	input wire logic push,
	input wire logic pop,
	input wire logic [7:0] push_data,
	output logic [7:0] pop_data
);
	logic [7:0] stk[$];
	initial pop_data = 8'h00;
	// last in first out, no high index
	always @(posedge sys_clk) begin
		if (push)
			stk.push_back(push_data);
		// idle line toggles so a stale byte never matches
		if (pop && stk.size() > 0)
			pop_data <= stk.pop_back();
		else
			pop_data <= ~pop_data;
	end
endmodule
`default_nettype wire

//--- tb/interrupt_latch_and_arbiter_tb.sv
/* self-checking bench of the interrupt latch and arbiter
 assumes the stack model and the bound checker */
`timescale 1ns/1ps
`default_nettype none
`include "intc_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module interrupt_latch_and_arbiter_tb;
	import intc_pkg::*;
	typedef struct {logic [21:0] s; logic [7:0] a, e;} row_t;
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, brk = 1'b0;
	logic [7:0] adr = 8'h00, wd = 8'h00, rdata, rd_v, pop_w;
	logic [21:0] src = 22'h00_0000, ena = 22'h00_0000;
	logic clr_ok, in_brk;
	cpu_in_t cin = '0, cpu_w;
	cpu_out_t co;
	logic [7:0] pq[$];
	int mismatches = 0, total_checks = 0;
	row_t rows[9] = '{'{22'h3F_FFFF, 8'h00, 8'hFC},
		'{22'h3F_FFFF, 8'h01, 8'hFF}, '{22'h3F_FFFF, 8'h02, 8'hFF},
		'{22'h15_5555, 8'h00, 8'h54}, '{22'h15_5555, 8'h01, 8'h55},
		'{22'h15_5555, 8'h02, 8'h55}, '{22'h00_0040, 8'h01, 8'h01},
		'{22'h00_0000, 8'h03, 8'h00}, '{22'h3F_FFFF, 8'h04, 8'h00}};
	interrupt_latch_and_arbiter dut_u (.SYS_CLK(clk), .RST(rst),
		.REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(wr_s), .REG_RD(rd_s),
		.REG_RDATA(rdata), .CPU_IN(cpu_w), .CPU_OUT(co), .SRC_REQ(src),
		.SRC_ENA(ena), .BRK_REQ(brk), .FLAG_CLR_OK(clr_ok),
		.IN_BREAK(in_brk));
	cpu_stack_model cpu_u (.sys_clk(clk), .push(co.stack_push),
		.pop(co.stack_pop), .push_data(co.stack_data), .pop_data(pop_w));
	always_comb begin
		cpu_w = cin;
		cpu_w.pop_data = pop_w;
	end
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (co.stack_push) pq.push_back(co.stack_data);
	////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		adr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 rd_v = rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// one-cycle cpu event, bit 6 insn_done down to bit 0 mask_clr
	task automatic ev(input logic [6:0] f);
		@(posedge clk);
		cin[54:48] <= f;
		@(posedge clk);
		cin[54:48] <= 7'h00;
	endtask
	task automatic vec(input logic [4:0] code, input bit none);
		int n;
		pq.delete();
		for (n = 0; n < 24; n++) begin
			@(posedge clk);
			#1;
			if (co.vec_valid === 1'b1)
				break;
		end
		if (none)
			`CHK(n, 24)
		else if (n == 24) begin
			mismatches++;
			finish_test();
		end else
			`CHK(co.vec_sel, code)
	endtask
	task automatic stk(input logic [7:0] e[5]);
		foreach (e[i]) `CHK(pq[i], e[i])
	endtask
	////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		vec(`VEC_RESET, 0);
		`CHK(co.mask, 1'b1)
		wr(`STAT2_IDX, 8'hFF);
		foreach (rows[i]) begin
			src <= rows[i].s;
			rd(rows[i].a);
			`CHK(rd_v, rows[i].e)
		end
		src <= 22'h00_0005;
		ena <= 22'h3F_FFFF;
		cin.pc <= 16'h1234;
		cin.acc <= 8'hA5;
		cin.idx <= 8'h3C;
		cin.ccr <= 8'h60;
		ev(7'h01);
		ev(7'h40);
		vec(5'h02, 0);
		stk('{8'h33, 8'h12, 8'h3C, 8'hA5, 8'h60});
		ev(7'h40);
		vec(5'h00, 1);
		cin.pc <= 16'h2000;
		ev(7'h20);
		vec(`VEC_SWI, 0);
		stk('{8'h00, 8'h20, 8'h3C, 8'hA5, 8'h68});
		ev(7'h10);
		vec(5'h00, 1);
		ev(7'h10);
		vec(5'h02, 0);
		stk('{8'hFF, 8'h1F, 8'h3C, 8'hA5, 8'h60});
		src <= 22'h00_0000;
		brk <= 1'b1;
		ev(7'h40);
		vec(`VEC_SWI, 0);
		`CHK(in_brk, 1'b1)
		`CHK(clr_ok, 1'b0)
		wr(`CTRL_IDX, 8'h01);
		rd(`CTRL_IDX);
		`CHK(rd_v, 8'h01)
		`CHK(clr_ok, 1'b1)
		brk <= 1'b0;
		wr(`CTRL_IDX, 8'h00);
		ev(7'h10);
		vec(5'h00, 1);
		`CHK(in_brk, 1'b0)
		ev(7'h08);
		#1 `CHK(co.hold, 1'b1)
		`CHK(co.mask, 1'b0)
		src <= 22'h04_0000;
		vec(5'h14, 0);
		`CHK(co.hold, 1'b0)
		src <= 22'h00_0000;
		ev(7'h04);
		#1 `CHK(co.hold, 1'b1)
		`CHK(co.mask, 1'b0)
		ev(7'h02);
		src <= 22'h04_0000;
		vec(5'h00, 1);
		`CHK(co.hold, 1'b1)
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		vec(`VEC_RESET, 0);
		`CHK(co.hold, 1'b0)
		`CHK(co.mask, 1'b1)
		finish_test();
	end
endmodule
bind interrupt_latch_and_arbiter intc_properties chk_u (.SYS_CLK(SYS_CLK),
	.RST(RST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.CPU_IN(CPU_IN), .CPU_OUT(CPU_OUT), .SRC_REQ(SRC_REQ),
	.BRK_REQ(BRK_REQ), .FLAG_CLR_OK(FLAG_CLR_OK), .IN_BREAK(IN_BREAK));
`default_nettype wire
